// *** design/bmmd_regs.svh ***
`ifndef BMMD_REGS_SVH
`define BMMD_REGS_SVH
`define BMMD_PC_W           21
`define BMMD_DADDR_W        12
`define BMMD_BANK_W         4
`define BMMD_OFS_W          8
`define BMMD_RESET_VEC      21'h000000
`define BMMD_INT_VEC_HI     21'h000008
`define BMMD_INT_VEC_LO     21'h000018
`define BMMD_FLASH_TOP_12K  21'h002fff
`define BMMD_KERN_TOP_12K   21'h003fff
`define BMMD_FLASH_TOP_24K  21'h005fff
`define BMMD_KERN_TOP_24K   21'h007fff
`define BMMD_RAM_TOP_640    12'h27f
`define BMMD_SCR_TOP_640    12'h2ff
`define BMMD_RAM_TOP_1408   12'h57f
`define BMMD_SCR_TOP_1408   12'h5ff
`define BMMD_SFR_BASE       12'hf80
`define BMMD_ACC_SPLIT      8'h80
`define BMMD_ACC_HI_BANK    4'hf
`define BMMD_RAM_DEPTH      1536
`define BMMD_RAM_AW         11
`define BMMD_SFR_DEPTH      128
`endif

// *** design/bmmd_pkg.sv ***
`default_nettype none
`include "bmmd_regs.svh"
package bmmd_pkg;
    typedef enum logic [0:0] {
        BMMD_CFG_SMALL = 1'b0,
        BMMD_CFG_LARGE = 1'b1
    } bmmd_cfg_t;

    typedef enum logic [1:0] {
        BMMD_MODE_ACCESS   = 2'b00,
        BMMD_MODE_BANKED   = 2'b01,
        BMMD_MODE_INDIRECT = 2'b10,
        BMMD_MODE_FULL     = 2'b11
    } bmmd_mode_t;

    typedef enum logic [1:0] {
        BMMD_PC_RUN    = 2'b00,
        BMMD_PC_VEC_HI = 2'b01,
        BMMD_PC_VEC_LO = 2'b10,
        BMMD_PC_LOAD   = 2'b11
    } bmmd_pcop_t;

    typedef struct packed {
        logic                       valid;
        logic                       write;
        bmmd_mode_t                 mode;
        logic [`BMMD_OFS_W-1:0]     offset;
        logic [1:0]                 ptrSel;
        logic [`BMMD_DADDR_W-1:0]   fullAddr;
        logic [7:0]                 wdata;
    } bmmd_dreq_t;

    typedef struct packed {
        logic                       valid;
        logic [`BMMD_DADDR_W-1:0]   addr;
        logic [7:0]                 rdata;
    } bmmd_dresp_t;
endpackage : bmmd_pkg
`default_nettype wire

// *** design/bmmd_ram.sv ***
`default_nettype none
module bmmd_ram #(
    parameter int DEPTH = 1536,
    parameter int AW    = 11
) (
    // clock
    input  wire logic          clk,
    // port
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    // no reset on the array: contents survive every reset
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule // bmmd_ram
`default_nettype wire

// *** design/bmmd_map.sv ***
// Operation
// - program counter is 21 bits wide
// - fetch beyond implemented range returns zero
// - 12K: flash to 2FFFh, kernel to 3FFFh
// - 24K: flash to 5FFFh, kernel to 7FFFh
// - fetch starts 0000h; interrupts vector 0008h/0018h
// - data addresses are 12 bits wide
// - sixteen 256-byte banks, bank from low nibble
// - upper bank select nibble not implemented
// - special registers F80h-FFFh; ram from bank 0
// - unimplemented data locations read zero
// - 640: ram to 27Fh, scratch to 2FFh
// - 1408: ram to 57Fh, scratch to 5FFh
// - pointers hold 12 bits, bypass bank select
// - access bank: low bank 0, high bank 15
// - ram not reset, kept over resets
// - file to file move: two words, two cycles
// - fetch and data buses run independently
`default_nettype none
`include "bmmd_regs.svh"
module bmmd_map
    import bmmd_pkg::*;
#(
    parameter bmmd_cfg_t CFG = BMMD_CFG_SMALL
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // program fetch side
    input  wire bmmd_pcop_t                pcOp,
    input  wire logic [`BMMD_PC_W-1:0]     pcLoad,
    output logic      [`BMMD_PC_W-1:0]     pcOut,
    output logic                           fetchValid,
    output logic      [`BMMD_PC_W-1:0]     flashAddr,
    input  wire logic [15:0]               flashData,
    input  wire logic [15:0]               kernelData,
    output logic      [15:0]               fetchData,
    // bank select and pointer writes
    input  wire logic                      bankWe,
    input  wire logic [7:0]                bankWdata,
    output logic      [7:0]                bankSelectReg,
    input  wire logic                      ptrWe,
    input  wire logic [1:0]                ptrWsel,
    input  wire logic [`BMMD_DADDR_W-1:0]  ptrWdata,
    // data access
    input  wire bmmd_dreq_t                dReq,
    output var bmmd_dresp_t                dResp,
    // special register bus, external to this block
    output logic                           sfrSel,
    output logic                           sfrWe,
    output logic      [6:0]                sfrAddr,
    output logic      [7:0]                sfrWdata,
    input  wire logic                      sfrHit,
    input  wire logic [7:0]                sfrRdata,
    input  wire logic [7:0]                scratchRdata,
    // file to file move
    input  wire logic                      moveStart,
    input  wire logic [`BMMD_DADDR_W-1:0]  moveSrc,
    input  wire logic [`BMMD_DADDR_W-1:0]  moveDst,
    output logic                           moveBusy,
    output logic                           moveDone
);
    localparam logic [`BMMD_PC_W-1:0] FLASH_TOP =
        (CFG == BMMD_CFG_LARGE) ? `BMMD_FLASH_TOP_24K : `BMMD_FLASH_TOP_12K;
    localparam logic [`BMMD_PC_W-1:0] KERN_TOP =
        (CFG == BMMD_CFG_LARGE) ? `BMMD_KERN_TOP_24K : `BMMD_KERN_TOP_12K;
    localparam logic [`BMMD_DADDR_W-1:0] RAM_TOP =
        (CFG == BMMD_CFG_LARGE) ? `BMMD_RAM_TOP_1408 : `BMMD_RAM_TOP_640;
    localparam logic [`BMMD_DADDR_W-1:0] SCR_TOP =
        (CFG == BMMD_CFG_LARGE) ? `BMMD_SCR_TOP_1408 : `BMMD_SCR_TOP_640;

    // ---------------- program side
    logic [`BMMD_PC_W-1:0] pc_q;
    logic                  fetchValid_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_q         <= `BMMD_RESET_VEC;
            fetchValid_q <= 1'b0;
        end else begin
            fetchValid_q <= 1'b1;
            unique case (pcOp)
                BMMD_PC_RUN:    pc_q <= pc_q + 21'h000002;
                BMMD_PC_VEC_HI: pc_q <= `BMMD_INT_VEC_HI;
                BMMD_PC_VEC_LO: pc_q <= `BMMD_INT_VEC_LO;
                BMMD_PC_LOAD:   pc_q <= pcLoad;
            endcase
        end
    end

    assign pcOut      = pc_q;
    assign flashAddr  = pc_q;
    assign fetchValid = fetchValid_q;

    // kernel area passes the kernel's own words; software sees them as random
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fetchData <= 16'h0000;
        end else if (pc_q <= FLASH_TOP) begin
            fetchData <= flashData;
        end else if (pc_q <= KERN_TOP) begin
            fetchData <= kernelData;
        end else begin
            fetchData <= 16'h0000;
        end
    end

    // ---------------- bank select and pointers
    logic [`BMMD_BANK_W-1:0]  bank_q;
    logic [`BMMD_DADDR_W-1:0] ptr_q [3];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bank_q <= 4'h0;
        end else if (bankWe) begin
            bank_q <= bankWdata[3:0];
        end
    end

    assign bankSelectReg = {4'h0, bank_q};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q[0] <= 12'h000;
            ptr_q[1] <= 12'h000;
            ptr_q[2] <= 12'h000;
        end else if (ptrWe && ptrWsel != 2'b11) begin
            ptr_q[ptrWsel] <= ptrWdata;
        end
    end

    // ---------------- file to file move, two cycles
    typedef enum logic [1:0] {
        MV_IDLE  = 2'b00,
        MV_READ  = 2'b01,
        MV_WRITE = 2'b10
    } mv_state_t;

    mv_state_t                mvState_q;
    logic [`BMMD_DADDR_W-1:0] mvSrc_q;
    logic [`BMMD_DADDR_W-1:0] mvDst_q;

    // both addresses held at the start pulse; the core may move on after it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mvState_q <= MV_IDLE;
            mvSrc_q   <= 12'h000;
            mvDst_q   <= 12'h000;
        end else begin
            unique case (mvState_q)
                MV_IDLE: if (moveStart) begin
                    mvState_q <= MV_READ;
                    mvSrc_q   <= moveSrc;
                    mvDst_q   <= moveDst;
                end
                MV_READ:  mvState_q <= MV_WRITE;
                MV_WRITE: mvState_q <= MV_IDLE;
                default:  mvState_q <= MV_IDLE;
            endcase
        end
    end

    assign moveBusy = (mvState_q != MV_IDLE);
    assign moveDone = (mvState_q == MV_WRITE);

    // ---------------- data address formation
    logic [`BMMD_DADDR_W-1:0] effAddr;
    logic                     effWe;
    logic                     effValid;
    logic [7:0]               effWdata;
    logic [7:0]               moveData;

    always_comb begin
        effAddr  = 12'h000;
        effWe    = 1'b0;
        effValid = 1'b0;
        effWdata = dReq.wdata;
        if (mvState_q == MV_READ) begin
            effAddr  = mvSrc_q;
            effValid = 1'b1;
        end else if (mvState_q == MV_WRITE) begin
            effAddr  = mvDst_q;
            effWe    = 1'b1;
            effValid = 1'b1;
            effWdata = moveData;
        end else if (dReq.valid) begin
            effWe    = dReq.write;
            effValid = 1'b1;
            unique case (dReq.mode)
                BMMD_MODE_ACCESS:
                    effAddr = (dReq.offset < `BMMD_ACC_SPLIT) ?
                        {4'h0, dReq.offset} :
                        {`BMMD_ACC_HI_BANK, dReq.offset};
                BMMD_MODE_BANKED:
                    effAddr = {bank_q, dReq.offset};
                BMMD_MODE_INDIRECT:
                    effAddr = (dReq.ptrSel == 2'b11) ? 12'h000 :
                              ptr_q[dReq.ptrSel];
                BMMD_MODE_FULL:
                    effAddr = dReq.fullAddr;
            endcase
        end
    end

    // ---------------- region decode
    logic inRam;
    logic inScratch;
    logic inSfr;

    always_comb begin
        inSfr     = (effAddr >= `BMMD_SFR_BASE);
        inRam     = (effAddr <= RAM_TOP);
        inScratch = !inRam && (effAddr <= SCR_TOP);
    end

    // ram holds user and scratch space up to the scratch top
    logic [7:0] ramRdata;

    bmmd_ram #(
        .DEPTH (`BMMD_RAM_DEPTH),
        .AW    (`BMMD_RAM_AW)
    ) u_ram (
        .clk   (clk),
        .we    (effWe && (inRam || inScratch) && (mvState_q != MV_READ)),
        .addr  (effAddr[`BMMD_RAM_AW-1:0]),
        .wdata (effWdata),
        .rdata (ramRdata)
    );

    // independent special register port; no read side effects beyond the owner
    assign sfrSel   = effValid && inSfr;
    assign sfrWe    = effValid && inSfr && effWe;
    assign sfrAddr  = effAddr[6:0];
    assign sfrWdata = effWdata;

    // ---------------- read return, two cycles after the access
    typedef enum logic [1:0] {
        SRC_ZERO = 2'b00,
        SRC_RAM  = 2'b01,
        SRC_SCR  = 2'b10,
        SRC_SFR  = 2'b11
    } src_t;

    src_t                     src_q;
    logic [7:0]               sfrData_q;
    logic [7:0]               scrData_q;
    logic                     rdValid_q;
    logic [`BMMD_DADDR_W-1:0] rdAddr_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            src_q     <= SRC_ZERO;
            sfrData_q <= 8'h00;
            scrData_q <= 8'h00;
            rdValid_q <= 1'b0;
            rdAddr_q  <= 12'h000;
        end else begin
            rdValid_q <= effValid && !effWe && (mvState_q == MV_IDLE);
            rdAddr_q  <= effAddr;
            sfrData_q <= sfrHit ? sfrRdata : 8'h00;
            scrData_q <= scratchRdata;
            if (inRam) begin
                src_q <= SRC_RAM;
            end else if (inScratch) begin
                src_q <= SRC_SCR;
            end else if (inSfr) begin
                src_q <= SRC_SFR;
            end else begin
                src_q <= SRC_ZERO;
            end
        end
    end

    logic [7:0] rdMux;

    // scratch reads hand back kernel data, mixed with the stored byte
    always_comb begin
        unique case (src_q)
            SRC_RAM:  rdMux = ramRdata;
            SRC_SCR:  rdMux = ramRdata ^ scrData_q;
            SRC_SFR:  rdMux = sfrData_q;
            SRC_ZERO: rdMux = 8'h00;
        endcase
    end

    assign moveData = rdMux;

    // data bus has its own path, so fetch never waits on it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dResp <= '0;
        end else begin
            dResp.valid <= rdValid_q;
            dResp.addr  <= rdAddr_q;
            dResp.rdata <= rdMux;
        end
    end
endmodule // bmmd_map
`default_nettype wire

// *** tb/bmmd_map_sva.sv ***
`default_nettype none
`include "bmmd_regs.svh"
module bmmd_map_sva
    import bmmd_pkg::*;
#(
    parameter bmmd_cfg_t CFG = BMMD_CFG_SMALL
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // fetch
    input wire bmmd_pcop_t  pcOp,
    input wire logic [20:0] pcOut,
    input wire logic        fetchValid,
    input wire logic [15:0] fetchData,
    // bank and data
    input wire logic        bankWe,
    input wire logic [7:0]  bankWdata,
    input wire logic [7:0]  bankSelectReg,
    input wire bmmd_dreq_t  dReq,
    input wire bmmd_dresp_t dResp,
    input wire logic        sfrSel,
    input wire logic [6:0]  sfrAddr,
    // move
    input wire logic        moveStart,
    input wire logic        moveBusy,
    input wire logic        moveDone
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [20:0] KTOP = (CFG == BMMD_CFG_LARGE) ? `BMMD_KERN_TOP_24K
                                                             : `BMMD_KERN_TOP_12K;
    logic [11:0] expAddr;
    assign expAddr = (dReq.mode == BMMD_MODE_ACCESS)
        ? {(dReq.offset >= 8'h80) ? 4'hf : 4'h0, dReq.offset}
        : {bankSelectReg[3:0], dReq.offset};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence rd_go_s;
        dReq.valid && !dReq.write && !moveBusy;
    endsequence
    sequence move_s;
        moveBusy && !moveDone ##1 moveBusy && moveDone ##1 !moveBusy;
    endsequence

    pc_run_step_a: assert property (pcOp == BMMD_PC_RUN && fetchValid |=>
        pcOut == $past(pcOut) + 21'h2) else $error("pc step wrong");
    vec_hi_a: assert property (pcOp == BMMD_PC_VEC_HI |=> pcOut == 21'h8)
        else $error("high vector wrong");
    vec_lo_a: assert property (pcOp == BMMD_PC_VEC_LO |=> pcOut == 21'h18)
        else $error("low vector wrong");
    fetch_zero_a: assert property (pcOut > KTOP |=> fetchData == 16'h0)
        else $error("fetch above kernel not zero");
    read_latency_a: assert property (rd_go_s |-> ##2 dResp.valid)
        else $error("read answer late");
    banked_addr_a: assert property (rd_go_s ##0 dReq.mode == BMMD_MODE_BANKED
        |-> ##2 dResp.addr == $past(expAddr, 2)) else $error("banked address wrong");
    access_addr_a: assert property (rd_go_s ##0 dReq.mode == BMMD_MODE_ACCESS
        |-> ##2 dResp.addr == $past(expAddr, 2)) else $error("access address wrong");
    bank_write_a: assert property (bankWe |=>
        bankSelectReg == {4'h0, $past(bankWdata[3:0])}) else $error("bank write wrong");
    sfr_sel_a: assert property (dReq.valid && !moveBusy && dReq.mode == BMMD_MODE_FULL
        && dReq.fullAddr >= 12'hf80 |-> sfrSel && sfrAddr == dReq.fullAddr[6:0])
        else $error("special strobe wrong");
    move_cycles_a: assert property (moveStart && !moveBusy |=> move_s)
        else $error("move timing wrong");
endmodule // bmmd_map_sva

bind bmmd_map bmmd_map_sva #(.CFG(CFG)) u_sva (
    .clk(clk), .rstn(rstn), .pcOp(pcOp), .pcOut(pcOut), .fetchValid(fetchValid),
    .fetchData(fetchData), .bankWe(bankWe), .bankWdata(bankWdata),
    .bankSelectReg(bankSelectReg), .dReq(dReq), .dResp(dResp), .sfrSel(sfrSel),
    .sfrAddr(sfrAddr), .moveStart(moveStart), .moveBusy(moveBusy), .moveDone(moveDone));
`default_nettype wire

// *** tb/bmmd_mem_model.sv ***
`default_nettype none
module bmmd_mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // fetch
    input  wire logic [20:0] flashAddr,
    output logic      [15:0] flashData,
    output logic      [15:0] kernelData,
    // special registers
    input  wire logic        sfrSel,
    input  wire logic [6:0]  sfrAddr,
    output logic             sfrHit,
    output logic      [7:0]  sfrRdata,
    output logic      [7:0]  scratchRdata
);
    timeunit 1ns;
    timeprecision 100ps;
    assign flashData = flashAddr[15:0] ^ 16'h5a5a;
    assign kernelData = ~flashAddr[15:0];
    // only lower half populated; misses drive noise so zeroing shows
    assign sfrHit = sfrSel && (sfrAddr < 7'h40);
    assign sfrRdata = sfrHit ? {1'b1, sfrAddr} : {1'b0, ~sfrAddr};
    // kernel scratch noise, a free running count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scratchRdata <= 8'h00;
        end else begin
            scratchRdata <= scratchRdata + 8'h01;
        end
    end
endmodule // bmmd_mem_model
`default_nettype wire

// *** tb/banked_memory_map_decoder_tb.sv ***
`default_nettype none
module banked_memory_map_decoder_tb
    import bmmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rstn, fetchValid, bankWe, ptrWe, sfrSel, sfrWe, sfrHit;
    logic moveStart, moveBusy, moveDone;
    bmmd_pcop_t pcOp;
    logic [20:0] pcLoad, pcOut, flashAddr;
    logic [15:0] flashData, kernelData, fetchData, fetchDataL;
    logic [7:0] bankWdata, bankSelectReg, sfrWdata, sfrRdata, scratchRdata;
    logic [6:0] sfrAddr;
    logic [1:0] ptrWsel;
    logic [11:0] ptrWdata, moveSrc, moveDst;
    bmmd_dreq_t dReq;
    bmmd_dresp_t dResp, r, dRespL, rL;
    int errors, checks_done;

    bmmd_map #(.CFG(BMMD_CFG_SMALL)) dut (.clk(clk), .rstn(rstn), .pcOp(pcOp),
        .pcLoad(pcLoad), .pcOut(pcOut), .fetchValid(fetchValid), .flashAddr(flashAddr),
        .flashData(flashData), .kernelData(kernelData), .fetchData(fetchData),
        .bankWe(bankWe), .bankWdata(bankWdata), .bankSelectReg(bankSelectReg),
        .ptrWe(ptrWe), .ptrWsel(ptrWsel), .ptrWdata(ptrWdata), .dReq(dReq), .dResp(dResp),
        .sfrSel(sfrSel), .sfrWe(sfrWe), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .sfrHit(sfrHit), .sfrRdata(sfrRdata), .scratchRdata(scratchRdata),
        .moveStart(moveStart), .moveSrc(moveSrc), .moveDst(moveDst),
        .moveBusy(moveBusy), .moveDone(moveDone));
    // large configuration shares every input; only fetch and data answers compared
    bmmd_map #(.CFG(BMMD_CFG_LARGE)) dutLarge (.clk(clk), .rstn(rstn), .pcOp(pcOp),
        .pcLoad(pcLoad), .pcOut(), .fetchValid(), .flashAddr(), .flashData(flashData),
        .kernelData(kernelData), .fetchData(fetchDataL), .bankWe(bankWe),
        .bankWdata(bankWdata), .bankSelectReg(), .ptrWe(ptrWe), .ptrWsel(ptrWsel),
        .ptrWdata(ptrWdata), .dReq(dReq), .dResp(dRespL), .sfrSel(), .sfrWe(),
        .sfrAddr(), .sfrWdata(), .sfrHit(sfrHit), .sfrRdata(sfrRdata),
        .scratchRdata(scratchRdata), .moveStart(moveStart), .moveSrc(moveSrc),
        .moveDst(moveDst), .moveBusy(), .moveDone());
    bmmd_mem_model u_mem (.clk(clk), .rstn(rstn), .flashAddr(flashAddr), .flashData(flashData),
        .kernelData(kernelData), .sfrSel(sfrSel), .sfrAddr(sfrAddr), .sfrHit(sfrHit),
        .sfrRdata(sfrRdata), .scratchRdata(scratchRdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one data access; offset, pointer select and full address share one value
    task automatic acc(input logic wr, input bmmd_mode_t md, input logic [11:0] a,
                       input logic [7:0] wd);
        @(posedge clk);
        dReq <= '{1'b1, wr, md, a[7:0], a[1:0], a, wd};
        @(posedge clk);
        dReq.valid <= 1'b0;
        @(posedge clk);
        #1 r = dResp;
        rL = dRespL;
        chk(r.valid, !wr);
    endtask
    task automatic pc_hold(input bmmd_pcop_t op, input logic [20:0] v);
        @(posedge clk);
        pcOp <= op;
        pcLoad <= v;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic set_bank(input logic [7:0] v);
        @(posedge clk);
        bankWe <= 1'b1;
        bankWdata <= v;
        @(posedge clk);
        bankWe <= 1'b0;
        #1;
    endtask

    task automatic test_fetch();
        pc_hold(BMMD_PC_LOAD, 21'h1fffff);
        chk(pcOut, 21'h1fffff);
        chk(flashAddr, 21'h1fffff);
        chk(fetchValid, 1'b1);
        chk(fetchData, 16'h0);
        pc_hold(BMMD_PC_LOAD, 21'h003000);
        chk(fetchData, 16'hcfff);
        pc_hold(BMMD_PC_LOAD, 21'h002ffe);
        chk(fetchData, 16'h75a4);
        pc_hold(BMMD_PC_VEC_HI, 21'h0);
        chk(pcOut, 21'h8);
        pc_hold(BMMD_PC_VEC_LO, 21'h0);
        chk(pcOut, 21'h18);
        @(posedge clk);
        pcOp <= BMMD_PC_RUN;
        repeat (3) @(posedge clk);
        #1 chk(pcOut, 21'h1e);
    endtask
    task automatic test_banks();
        set_bank(8'hf1);
        chk(bankSelectReg, 8'h01);
        acc(1'b1, BMMD_MODE_BANKED, 12'h010, 8'h77);
        acc(1'b0, BMMD_MODE_FULL, 12'h110, 8'h0);
        chk(r.rdata, 8'h77);
        set_bank(8'h02);
        @(posedge clk);
        ptrWe <= 1'b1;
        ptrWsel <= 2'd1;
        ptrWdata <= 12'h110;
        @(posedge clk);
        ptrWe <= 1'b0;
        acc(1'b0, BMMD_MODE_INDIRECT, 12'h001, 8'h0);
        chk(r.rdata, 8'h77);
        acc(1'b0, BMMD_MODE_INDIRECT, 12'h003, 8'h0);
        chk(r.addr, 12'h000);
        acc(1'b0, BMMD_MODE_BANKED, 12'h010, 8'h0);
        chk(r.addr, 12'h210);
    endtask
    task automatic test_access();
        acc(1'b1, BMMD_MODE_ACCESS, 12'h020, 8'h3c);
        acc(1'b0, BMMD_MODE_FULL, 12'h020, 8'h0);
        chk(r.rdata, 8'h3c);
        acc(1'b0, BMMD_MODE_ACCESS, 12'h090, 8'h0);
        chk(r.addr, 12'hf90);
        chk(r.rdata, 8'h90);
        acc(1'b0, BMMD_MODE_FULL, 12'hff0, 8'h0);
        chk(r.rdata, 8'h0);
        acc(1'b0, BMMD_MODE_FULL, 12'h700, 8'h0);
        chk(r.rdata, 8'h0);
        @(posedge clk);
        dReq <= '{1'b1, 1'b1, BMMD_MODE_FULL, 8'h85, 2'b01, 12'hf85, 8'h5e};
        #1 chk(sfrWe, 1'b1);
        chk(sfrAddr, 7'h05);
        chk(sfrWdata, 8'h5e);
        @(posedge clk);
        dReq.valid <= 1'b0;
    endtask
    task automatic test_large();
        pc_hold(BMMD_PC_LOAD, 21'h003000);
        chk(fetchDataL, 16'h6a5a);
        pc_hold(BMMD_PC_LOAD, 21'h006000);
        chk(fetchDataL, 16'h9fff);
        chk(fetchData, 16'h0000);
        pc_hold(BMMD_PC_LOAD, 21'h008000);
        chk(fetchDataL, 16'h0000);
        acc(1'b1, BMMD_MODE_FULL, 12'h500, 8'h4b);
        acc(1'b0, BMMD_MODE_FULL, 12'h500, 8'h0);
        chk(rL.rdata, 8'h4b);
        chk(r.rdata, 8'h00);
    endtask
    task automatic test_move_reset();
        acc(1'b1, BMMD_MODE_FULL, 12'h021, 8'ha5);
        @(posedge clk);
        moveStart <= 1'b1;
        moveSrc <= 12'h021;
        moveDst <= 12'h130;
        @(posedge clk);
        moveStart <= 1'b0;
        @(posedge clk);
        #1 chk(moveDone, 1'b1);
        acc(1'b0, BMMD_MODE_FULL, 12'h130, 8'h0);
        chk(r.rdata, 8'ha5);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        acc(1'b0, BMMD_MODE_FULL, 12'h110, 8'h0);
        chk(r.rdata, 8'h77);
    endtask

    initial begin
        rstn = 1'b0; pcOp = BMMD_PC_RUN; pcLoad = '0; bankWe = 1'b0; bankWdata = '0;
        ptrWe = 1'b0; ptrWsel = '0; ptrWdata = '0; dReq = '0; moveStart = 1'b0;
        moveSrc = '0; moveDst = '0; errors = 0; checks_done = 0;
        repeat (8) @(posedge clk);
        #1 chk(pcOut, 21'h0);
        chk(fetchValid, 1'b0);
        @(posedge clk);
        rstn <= 1'b1;
        test_fetch();
        test_banks();
        test_access();
        // reserved special registers are never written here
        test_large();
        test_move_reset();
        final_report();
    end
    initial begin
        #20000;
        errors++;
        final_report();
    end
endmodule // banked_memory_map_decoder_tb
`default_nettype wire
